// [hw/pdvd_consts.svh]
// Timing and sizing constants of the voltage decrease sequencer
`ifndef PDVD_CONSTS_SVH
`define PDVD_CONSTS_SVH

// Clock rate in MHz; the period is 5 ns
`define PDVD_CLK_MHZ 200
// Width of every interval counter
`define PDVD_CNT_W 24

// Intervals in microseconds; plain defaults, adjust per product
`define PDVD_T_SRC_TRANS_US 30
`define PDVD_T_SRC_READY_US 300
`define PDVD_T_SNK_STDBY_US 20
`define PDVD_T_PS_TRANS_US 600

// Interval counts in cycles, derived from the figures above
`define PDVD_T_SRC_TRANS_CYC (`PDVD_T_SRC_TRANS_US * `PDVD_CLK_MHZ)
`define PDVD_T_SRC_READY_CYC (`PDVD_T_SRC_READY_US * `PDVD_CLK_MHZ)
`define PDVD_T_SNK_STDBY_CYC (`PDVD_T_SNK_STDBY_US * `PDVD_CLK_MHZ)
`define PDVD_T_PS_TRANS_CYC (`PDVD_T_PS_TRANS_US * `PDVD_CLK_MHZ)

`endif

// [hw/pdvd_pkg.sv]
// Types shared by the source and sink sequencers
`include "pdvd_consts.svh"
package pdvd_pkg;

   typedef logic [`PDVD_CNT_W-1:0] pdvd_cnt_t;

   typedef enum logic [1:0] {
      PDVD_MSG_NONE,
      PDVD_MSG_ACCEPT,
      PDVD_MSG_PS_RDY
   } pdvd_msg_t;

   typedef enum logic [2:0] {
      PDVD_SRC_IDLE,
      PDVD_SRC_WAIT_ACC_CRC,
      PDVD_SRC_WAIT_TRANS,
      PDVD_SRC_WAIT_READY,
      PDVD_SRC_WAIT_RDY_CRC
   } pdvd_src_state_t;

   typedef enum logic [2:0] {
      PDVD_SNK_IDLE,
      PDVD_SNK_EVAL_ACC,
      PDVD_SNK_STANDBY,
      PDVD_SNK_WAIT_PS_RDY,
      PDVD_SNK_EVAL_RDY
   } pdvd_snk_state_t;

   typedef struct packed {
      pdvd_src_state_t state;
      pdvd_cnt_t cnt;
      logic msg_valid;
      pdvd_msg_t msg_type;
      logic supply_change;
      logic ready_late;
      logic busy;
      logic done;
      logic aborted;
   } pdvd_src_st_t;

   typedef struct packed {
      pdvd_snk_state_t state;
      pdvd_cnt_t pst_cnt;
      pdvd_cnt_t stby_cnt;
      logic rdy_pending;
      logic crc_valid;
      logic standby_req;
      logic stdby_late;
      logic new_level_ok;
      logic ps_timeout;
   } pdvd_snk_st_t;

endpackage : pdvd_pkg

// [hw/pdvd_if.sv]
// Message link between the source and sink sequencers
`timescale 1ns/1ps
`default_nettype none
interface pdvd_if;
   // Source to sink message, one-cycle strobe with its type
   logic msg_valid;
   pdvd_pkg::pdvd_msg_t msg_type;
   // Sink to source acknowledgement, one-cycle strobe
   logic crc_valid;

   modport src (
      output msg_valid,
      output msg_type,
      input crc_valid
   );

   modport snk (
      input msg_valid,
      input msg_type,
      output crc_valid
   );
endinterface : pdvd_if
`default_nettype wire

// [hw/pdvd_source.sv]
// Source end of the voltage decrease sequence
//
// Behaviour
// - Source sends Accept; sink starts transition timer
// - After Accept GoodCRC, wait tSrcTransition, then command
// - Sink cuts to standby within tSnkStdby
// - Sink standby finishes before tSrcTransition ends
// - Supply ready at new voltage within tSrcReady
// - Supply readiness reaches engine before proceeding
// - On readiness send PS_RDY, await GoodCRC
// - Sink acknowledges PS_RDY, permits new level
// - Sink draws new level after unspecified delay
`timescale 1ns/1ps
`default_nettype none
`include "pdvd_consts.svh"

module pdvd_source #(
   parameter int unsigned T_SRC_TRANS_CYC = `PDVD_T_SRC_TRANS_CYC,
   parameter int unsigned T_SRC_READY_CYC = `PDVD_T_SRC_READY_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link to the sink
   pdvd_if.src link,
   // Device policy manager side
   input wire logic start,
   input wire logic abort,
   input wire logic supply_ready,
   output logic supply_change,
   output logic ready_late,
   output logic busy,
   output logic done,
   output logic aborted
);

   localparam int unsigned CNT_MAX = (1 << `PDVD_CNT_W) - 1;

   // Counter must stay narrower than the int used for range checks
   if (`PDVD_CNT_W < 1 || `PDVD_CNT_W > 31) begin : g_bad_width
      $error("pdvd_source: counter width out of range");
   end

   // Counts must fit the counter and take at least one cycle
   if (T_SRC_TRANS_CYC < 1 || T_SRC_TRANS_CYC > CNT_MAX) begin : g_bad_trans
      $error("pdvd_source: T_SRC_TRANS_CYC out of range");
   end
   if (T_SRC_READY_CYC < 1 || T_SRC_READY_CYC > CNT_MAX) begin : g_bad_ready
      $error("pdvd_source: T_SRC_READY_CYC out of range");
   end

   localparam pdvd_pkg::pdvd_cnt_t TRANS_LOAD =
      pdvd_pkg::pdvd_cnt_t'(T_SRC_TRANS_CYC - 1);
   localparam pdvd_pkg::pdvd_cnt_t READY_LOAD =
      pdvd_pkg::pdvd_cnt_t'(T_SRC_READY_CYC - 1);

   pdvd_pkg::pdvd_src_st_t s;
   pdvd_pkg::pdvd_src_st_t next_s;
   // GoodCRC seen while one is awaited
   logic ack_taken;

   // Launch a message toward the sink for one cycle
   function automatic pdvd_pkg::pdvd_src_st_t send_msg(
      input pdvd_pkg::pdvd_src_st_t cur,
      input pdvd_pkg::pdvd_msg_t kind
   );
      pdvd_pkg::pdvd_src_st_t r;
      r = cur;
      r.msg_valid = 1'b1;
      r.msg_type = kind;
      return r;
   endfunction : send_msg

   // Shared step of both timed waits; holds at zero
   function automatic pdvd_pkg::pdvd_cnt_t count_down(
      input pdvd_pkg::pdvd_cnt_t cur
   );
      pdvd_pkg::pdvd_cnt_t r;
      r = cur;
      if (cur != '0) begin
         r = cur - 1'b1;
      end
      return r;
   endfunction : count_down

   // A stray GoodCRC outside these waits must not move the sequence
   function automatic logic ack_expected(
      input pdvd_pkg::pdvd_src_state_t st
   );
      return st == pdvd_pkg::PDVD_SRC_WAIT_ACC_CRC ||
             st == pdvd_pkg::PDVD_SRC_WAIT_RDY_CRC;
   endfunction : ack_expected

   // Every one-cycle strobe back to its idle value
   function automatic pdvd_pkg::pdvd_src_st_t clear_strobes(
      input pdvd_pkg::pdvd_src_st_t cur
   );
      pdvd_pkg::pdvd_src_st_t r;
      r = cur;
      r.msg_valid = 1'b0;
      r.msg_type = pdvd_pkg::PDVD_MSG_NONE;
      r.supply_change = 1'b0;
      r.done = 1'b0;
      r.aborted = 1'b0;
      return r;
   endfunction : clear_strobes

   assign ack_taken = link.crc_valid && ack_expected(s.state);

   always_comb begin
      next_s = s;
      // Strobes last a single cycle
      next_s = clear_strobes(next_s);

      case (s.state)
         pdvd_pkg::PDVD_SRC_IDLE: begin
            next_s.busy = 1'b0;
            if (start && !abort) begin
               next_s = send_msg(next_s, pdvd_pkg::PDVD_MSG_ACCEPT);
               next_s.ready_late = 1'b0;
               next_s.busy = 1'b1;
               next_s.state = pdvd_pkg::PDVD_SRC_WAIT_ACC_CRC;
            end
         end

         pdvd_pkg::PDVD_SRC_WAIT_ACC_CRC: begin
            // No timeout here: resending is the protocol layer's job
            if (ack_taken) begin
               next_s.cnt = TRANS_LOAD;
               next_s.state = pdvd_pkg::PDVD_SRC_WAIT_TRANS;
            end
         end

         pdvd_pkg::PDVD_SRC_WAIT_TRANS: begin
            if (s.cnt == '0) begin
               next_s.supply_change = 1'b1;
               next_s.cnt = READY_LOAD;
               next_s.state = pdvd_pkg::PDVD_SRC_WAIT_READY;
            end else begin
               next_s.cnt = count_down(s.cnt);
            end
         end

         pdvd_pkg::PDVD_SRC_WAIT_READY: begin
            if (supply_ready) begin
               next_s = send_msg(next_s, pdvd_pkg::PDVD_MSG_PS_RDY);
               next_s.state = pdvd_pkg::PDVD_SRC_WAIT_RDY_CRC;
            end else if (s.cnt == '0) begin
               // Late supply is flagged, yet PS_RDY still waits for it
               next_s.ready_late = 1'b1;
            end else begin
               next_s.cnt = count_down(s.cnt);
            end
         end

         pdvd_pkg::PDVD_SRC_WAIT_RDY_CRC: begin
            if (ack_taken) begin
               next_s.done = 1'b1;
               next_s.busy = 1'b0;
               next_s.state = pdvd_pkg::PDVD_SRC_IDLE;
            end
         end

         default: begin
            next_s.state = pdvd_pkg::PDVD_SRC_IDLE;
         end
      endcase

      // Abort wins over every step of a running sequence
      if (abort && s.state != pdvd_pkg::PDVD_SRC_IDLE) begin
         // Pending strobes are dropped, then the abort reports itself
         next_s = clear_strobes(next_s);
         next_s.busy = 1'b0;
         next_s.aborted = 1'b1;
         next_s.cnt = '0;
         next_s.state = pdvd_pkg::PDVD_SRC_IDLE;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '{state: pdvd_pkg::PDVD_SRC_IDLE,
                cnt: '0,
                msg_valid: 1'b0,
                msg_type: pdvd_pkg::PDVD_MSG_NONE,
                supply_change: 1'b0,
                ready_late: 1'b0,
                busy: 1'b0,
                done: 1'b0,
                aborted: 1'b0};
      end else begin
         s <= next_s;
      end
   end

   // Link
   assign link.msg_valid = s.msg_valid;
   assign link.msg_type = s.msg_type;

   // Power manager side
   assign supply_change = s.supply_change;
   assign ready_late = s.ready_late;
   assign busy = s.busy;
   assign done = s.done;
   assign aborted = s.aborted;

endmodule : pdvd_source
`default_nettype wire

// [hw/pdvd_sink.sv]
// Sink end of the voltage decrease sequence
`timescale 1ns/1ps
`default_nettype none
`include "pdvd_consts.svh"
module pdvd_sink #(
   parameter int unsigned T_SNK_STDBY_CYC = `PDVD_T_SNK_STDBY_CYC,
   parameter int unsigned T_PS_TRANS_CYC = `PDVD_T_PS_TRANS_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link to the source
   pdvd_if.snk link,
   // Device policy manager side
   input wire logic standby_done,
   output logic standby_req,
   output logic stdby_late,
   output logic new_level_ok,
   output logic ps_timeout
);

   localparam int unsigned CNT_MAX = (1 << `PDVD_CNT_W) - 1;

   if (T_SNK_STDBY_CYC < 1 || T_SNK_STDBY_CYC > CNT_MAX) begin : g_bad_stby
      $error("pdvd_sink: T_SNK_STDBY_CYC out of range");
   end
   if (T_PS_TRANS_CYC < 1 || T_PS_TRANS_CYC > CNT_MAX) begin : g_bad_pst
      $error("pdvd_sink: T_PS_TRANS_CYC out of range");
   end

   localparam pdvd_pkg::pdvd_cnt_t STBY_LOAD =
      pdvd_pkg::pdvd_cnt_t'(T_SNK_STDBY_CYC - 1);
   localparam pdvd_pkg::pdvd_cnt_t PST_LOAD =
      pdvd_pkg::pdvd_cnt_t'(T_PS_TRANS_CYC - 1);

   pdvd_pkg::pdvd_snk_st_t s;
   pdvd_pkg::pdvd_snk_st_t next_s;
   logic got_accept;
   logic got_ps_rdy;

   assign got_accept = link.msg_valid &&
                       link.msg_type == pdvd_pkg::PDVD_MSG_ACCEPT;
   assign got_ps_rdy = link.msg_valid &&
                       link.msg_type == pdvd_pkg::PDVD_MSG_PS_RDY;

   always_comb begin
      next_s = s;
      next_s.crc_valid = 1'b0;
      next_s.ps_timeout = 1'b0;
      if (s.pst_cnt != '0) begin
         next_s.pst_cnt = s.pst_cnt - 1'b1;
      end

      case (s.state)
         pdvd_pkg::PDVD_SNK_IDLE: begin
            if (got_accept) begin
               next_s.crc_valid = 1'b1;
               next_s.pst_cnt = PST_LOAD;
               next_s.new_level_ok = 1'b0;
               next_s.stdby_late = 1'b0;
               next_s.rdy_pending = 1'b0;
               next_s.state = pdvd_pkg::PDVD_SNK_EVAL_ACC;
            end
         end

         pdvd_pkg::PDVD_SNK_EVAL_ACC: begin
            next_s.standby_req = 1'b1;
            next_s.stby_cnt = STBY_LOAD;
            next_s.state = pdvd_pkg::PDVD_SNK_STANDBY;
         end

         pdvd_pkg::PDVD_SNK_STANDBY: begin
            // An early PS_RDY is acknowledged but held until standby
            if (got_ps_rdy) begin
               next_s.crc_valid = 1'b1;
               next_s.rdy_pending = 1'b1;
            end
            if (standby_done) begin
               next_s.standby_req = 1'b0;
               next_s.state = (s.rdy_pending || got_ps_rdy) ?
                  pdvd_pkg::PDVD_SNK_EVAL_RDY :
                  pdvd_pkg::PDVD_SNK_WAIT_PS_RDY;
            end else if (s.stby_cnt == '0) begin
               next_s.stdby_late = 1'b1;
            end else begin
               next_s.stby_cnt = s.stby_cnt - 1'b1;
            end
         end

         pdvd_pkg::PDVD_SNK_WAIT_PS_RDY: begin
            if (got_ps_rdy) begin
               next_s.crc_valid = 1'b1;
               next_s.state = pdvd_pkg::PDVD_SNK_EVAL_RDY;
            end else if (s.pst_cnt == '0) begin
               next_s.ps_timeout = 1'b1;
               next_s.state = pdvd_pkg::PDVD_SNK_IDLE;
            end
         end

         pdvd_pkg::PDVD_SNK_EVAL_RDY: begin
            // Permission only; the load moves whenever it likes
            next_s.new_level_ok = 1'b1;
            next_s.rdy_pending = 1'b0;
            next_s.pst_cnt = '0;
            next_s.state = pdvd_pkg::PDVD_SNK_IDLE;
         end

         default: begin
            next_s.state = pdvd_pkg::PDVD_SNK_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '{state: pdvd_pkg::PDVD_SNK_IDLE, default: '0};
      end else begin
         s <= next_s;
      end
   end

   assign link.crc_valid = s.crc_valid;
   assign standby_req = s.standby_req;
   assign stdby_late = s.stdby_late;
   assign new_level_ok = s.new_level_ok;
   assign ps_timeout = s.ps_timeout;

endmodule : pdvd_sink
`default_nettype wire

// [dv/pdvd_sva.sv]
// Checker for the voltage decrease link and both ends' user sides
`timescale 1ns/1ps
`default_nettype none
module pdvd_sva #(
   parameter int T_SRC_TRANS_CYC = 20
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Link
   input wire logic msg_valid,
   input wire pdvd_pkg::pdvd_msg_t msg_type,
   input wire logic crc_valid,
   // Source user side
   input wire logic start,
   input wire logic abort,
   input wire logic supply_ready,
   input wire logic supply_change,
   input wire logic busy,
   input wire logic done,
   // Sink user side
   input wire logic standby_done,
   input wire logic standby_req,
   input wire logic new_level_ok
);
   localparam int TR1 = T_SRC_TRANS_CYC + 1;
   logic wait_rdy;
   wire logic acc = msg_valid && msg_type == pdvd_pkg::PDVD_MSG_ACCEPT;
   wire logic rdy = msg_valid && msg_type == pdvd_pkg::PDVD_MSG_PS_RDY;

   // Supply commanded, PS_RDY not yet sent
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_rdy <= 1'b0;
      end else begin
         wait_rdy <= (wait_rdy || supply_change) && !rdy && busy && !abort;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_start_accept;
      start && !busy && !done && !abort |=> acc && busy;
   endproperty
   a_start_accept: assert property (p_start_accept)
      else $error("start gave no accept");
   property p_crc_answer;
      msg_valid |=> crc_valid;
   endproperty
   a_crc_answer: assert property (p_crc_answer)
      else $error("message not acknowledged");
   // Abort may cut the wait short, hence the escape on busy
   property p_trans_wait;
      crc_valid && $past(acc) |-> ##TR1 (supply_change || !busy);
   endproperty
   a_trans_wait: assert property (p_trans_wait)
      else $error("supply not commanded after transition wait");
   property p_change_cause;
      supply_change |-> $past(crc_valid, TR1);
   endproperty
   a_change_cause: assert property (p_change_cause)
      else $error("supply commanded at wrong time");
   property p_ready_psrdy;
      (wait_rdy || supply_change) && supply_ready && !abort && !rdy |=> rdy;
   endproperty
   a_ready_psrdy: assert property (p_ready_psrdy)
      else $error("supply ready did not send ps_rdy");
   property p_done;
      rdy ##1 crc_valid |=> done && !busy;
   endproperty
   a_done: assert property (p_done)
      else $error("sequence not finished after ps_rdy ack");
   property p_stby_req;
      crc_valid && $past(acc) |=> standby_req;
   endproperty
   a_stby_req: assert property (p_stby_req)
      else $error("standby not requested");
   property p_stby_drop;
      standby_req && standby_done |=> !standby_req;
   endproperty
   a_stby_drop: assert property (p_stby_drop)
      else $error("standby request not dropped");
   property p_level_ok;
      rdy && !standby_req |-> ##2 new_level_ok;
   endproperty
   a_level_ok: assert property (p_level_ok)
      else $error("new level not permitted");
   property p_level_cause;
      $rose(new_level_ok) |-> $past(crc_valid);
   endproperty
   a_level_cause: assert property (p_level_cause)
      else $error("new level permitted too early");

   c_run: cover property (rdy ##1 crc_valid ##1 done);
   c_stby: cover property (standby_req && standby_done);
   c_abort: cover property (busy && abort);
endmodule : pdvd_sva
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the source and sink sequencers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int NT = 20;
   localparam int NR = 40;
   logic clk, rst, start, abort, supply_ready, standby_done, stby_fast;
   logic supply_change, ready_late, busy, done, aborted;
   logic standby_req, stdby_late, new_level_ok, ps_timeout;
   int mismatches, comparisons, exp_acc;
   int accepts = 0;

   pdvd_if pdvd_if_i ();
   pdvd_source #(.T_SRC_TRANS_CYC(NT), .T_SRC_READY_CYC(NR)) pdvd_source_i (
      .clk(clk), .rst(rst), .link(pdvd_if_i), .start(start), .abort(abort),
      .supply_ready(supply_ready), .supply_change(supply_change),
      .ready_late(ready_late), .busy(busy), .done(done), .aborted(aborted));
   pdvd_sink #(.T_SNK_STDBY_CYC(8), .T_PS_TRANS_CYC(200)) pdvd_sink_i (
      .clk(clk), .rst(rst), .link(pdvd_if_i), .standby_done(standby_done),
      .standby_req(standby_req), .stdby_late(stdby_late),
      .new_level_ok(new_level_ok), .ps_timeout(ps_timeout));
   pdvd_sva #(.T_SRC_TRANS_CYC(NT)) pdvd_sva_i (
      .clk(clk), .rst(rst), .msg_valid(pdvd_if_i.msg_valid),
      .msg_type(pdvd_if_i.msg_type), .crc_valid(pdvd_if_i.crc_valid),
      .start(start), .abort(abort), .supply_ready(supply_ready),
      .supply_change(supply_change), .busy(busy), .done(done),
      .standby_done(standby_done), .standby_req(standby_req),
      .new_level_ok(new_level_ok));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Sink power manager answers one cycle after the request
   always @(negedge clk) standby_done <= standby_req && stby_fast;

   always @(posedge clk) begin
      if (pdvd_if_i.msg_valid === 1'b1 &&
          pdvd_if_i.msg_type === pdvd_pkg::PDVD_MSG_ACCEPT) begin
         accepts++;
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : cyc

   task automatic end_of_test();
      if (mismatches == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   // Start held a second cycle, which a busy source must ignore
   task automatic run(input int rd, input bit slow, input bit late);
      stby_fast = !slow;
      start = 1'b1;
      exp_acc++;
      cyc(1);
      chk(busy, 1'b1);
      cyc(1);
      start = 1'b0;
      cyc(1);
      chk(standby_req, 1'b1);
      chk(ready_late, 1'b0);
      if (slow) begin
         cyc(5);
         chk(stdby_late, 1'b0);
         cyc(6);
         chk(stdby_late, 1'b1);
         stby_fast = 1'b1;
         cyc(NT - 12);
      end else begin
         cyc(NT - 1);
      end
      chk(supply_change, 1'b0);
      cyc(1);
      chk(supply_change, 1'b1);
      if (late) begin
         cyc(NR - 3);
         chk(ready_late, 1'b0);
         cyc(6);
         chk(ready_late, 1'b1);
      end else begin
         cyc(rd);
      end
      supply_ready = 1'b1;
      cyc(1);
      supply_ready = 1'b0;
      cyc(2);
      chk(done, 1'b1);
      chk(busy, 1'b0);
      chk(new_level_ok, 1'b1);
      chk(accepts, exp_acc);
      cyc(1);
   endtask : run

   initial begin
      rst = 1'b1;
      start = 1'b0;
      abort = 1'b0;
      supply_ready = 1'b0;
      stby_fast = 1'b1;
      mismatches = 0;
      comparisons = 0;
      exp_acc = 0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      cyc(1);
      run(2, 1'b0, 1'b0);
      run(0, 1'b1, 1'b0);
      run(0, 1'b0, 1'b1);
      // Abort mid wait; sink must time out on its own
      start = 1'b1;
      exp_acc++;
      cyc(1);
      start = 1'b0;
      cyc(4);
      abort = 1'b1;
      cyc(1);
      abort = 1'b0;
      chk(aborted, 1'b1);
      chk(busy, 1'b0);
      for (int i = 0; i < 250 && ps_timeout !== 1'b1; i++) cyc(1);
      chk(ps_timeout, 1'b1);
      chk(supply_change, 1'b0);
      cyc(2);
      run(1, 1'b0, 1'b0);
      end_of_test();
   end

   initial begin
      cyc(3000);
      mismatches++;
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
